// File: hw/ivd_dispatch.sv
// Interrupt vector dispatch: vector fetch addresses, offset register and pending flag
`timescale 1ns/10ps
module ivd_dispatch #(
    parameter int OFFSET_W = ivd_pkg::OFFSET_W
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_ack_level_one,
    input  wire logic                        i_ack_level_two,
    input  wire logic                        i_ack_nmi,
    input  wire logic                        i_offset_valid,
    input  wire logic [OFFSET_W-1:0]         i_offset,
    input  wire logic                        i_offset_evmgr,
    input  wire logic                        i_read_req,
    output logic                             o_fetch_valid,
    output logic [ivd_pkg::ADDR_W-1:0]       o_fetch_addr,
    output logic                             o_read_done,
    output logic [OFFSET_W-1:0]              o_read_data,
    output logic [ivd_pkg::STATUS_W-1:0]     o_system_status_word_zero,
    output logic                             o_vector_read_pending
);

    typedef struct packed {
        ivd_pkg::ivd_fsm_type        fsm;
        logic [ivd_pkg::ADDR_W-1:0]  base;
        logic                        fetch_valid;
        logic [ivd_pkg::ADDR_W-1:0]  fetch_addr;
        logic [OFFSET_W-1:0]         vector_offset_register;
        logic                        src_evmgr;
        logic                        pending;
        logic                        busy;
        logic [2:0]                  wait_cnt;
        logic                        read_done;
        logic [OFFSET_W-1:0]         read_data;
    } ivd_state_type;

    ivd_state_type st;
    ivd_state_type next_st;
    logic          ack_mask;
    logic          ack_any;
    logic          read_start;

    assign ack_mask   = i_ack_level_one | i_ack_level_two;
    assign ack_any    = ack_mask | i_ack_nmi;
    assign read_start = i_read_req & ~st.busy;

    // Next-state logic; one acknowledge at a time, non-maskable takes priority
    always_comb begin
        next_st             = st;
        next_st.fetch_valid = 1'b0;
        next_st.read_done   = 1'b0;
        case (st.fsm)
            ivd_pkg::IVD_IDLE: begin
                if (i_ack_nmi) begin
                    next_st.base = ivd_pkg::VEC_NMI;
                    next_st.fsm  = ivd_pkg::IVD_FETCH0;
                end else if (i_ack_level_two) begin
                    next_st.base = ivd_pkg::VEC_LEVEL_TWO;
                    next_st.fsm  = ivd_pkg::IVD_FETCH0;
                end else if (i_ack_level_one) begin
                    next_st.base = ivd_pkg::VEC_LEVEL_ONE;
                    next_st.fsm  = ivd_pkg::IVD_FETCH0;
                end
            end
            ivd_pkg::IVD_FETCH0: begin
                next_st.fetch_valid = 1'b1;
                next_st.fetch_addr  = st.base;
                next_st.fsm         = ivd_pkg::IVD_FETCH1;
            end
            ivd_pkg::IVD_FETCH1: begin
                // Second word of the branch follows the first
                next_st.fetch_valid = 1'b1;
                next_st.fetch_addr  = st.base + {{(ivd_pkg::ADDR_W-2){1'b0}}, ivd_pkg::WORD_ONE};
                next_st.fsm         = ivd_pkg::IVD_IDLE;
            end
            default: begin
                next_st.fsm = ivd_pkg::IVD_IDLE;
            end
        endcase

        // Offset load on maskable acknowledge only; the NMI path never writes here
        if (ack_mask && !i_ack_nmi && st.fsm == ivd_pkg::IVD_IDLE) begin
            if (i_offset_valid) begin
                next_st.vector_offset_register = i_offset;
                next_st.src_evmgr              = i_offset_evmgr;
            end else begin
                next_st.vector_offset_register = OFFSET_W'(ivd_pkg::PHANTOM_OFFSET);
                next_st.src_evmgr              = 1'b0;
            end
        end

        // Read engine: data is sampled at start so the wait cannot see a later load
        if (read_start) begin
            next_st.busy      = 1'b1;
            next_st.read_data = st.vector_offset_register;
            next_st.wait_cnt  = st.src_evmgr ? ivd_pkg::WAIT_EVMGR : ivd_pkg::WAIT_PERIPH;
        end else if (st.busy) begin
            if (st.wait_cnt == ivd_pkg::WAIT_ZERO) begin
                next_st.busy      = 1'b0;
                next_st.read_done = 1'b1;
            end else begin
                next_st.wait_cnt = st.wait_cnt - 3'h1;
            end
        end

        // Pending flag: the load beats a read that clears in the same cycle
        if (ack_mask && !i_ack_nmi && st.fsm == ivd_pkg::IVD_IDLE) begin
            next_st.pending = 1'b1;
        end else if (read_start) begin
            next_st.pending = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st.fsm                    <= ivd_pkg::IVD_IDLE;
            st.base                   <= '0;
            st.fetch_valid            <= 1'b0;
            st.fetch_addr             <= '0;
            st.vector_offset_register <= OFFSET_W'(ivd_pkg::OFFSET_RESET);
            st.src_evmgr              <= 1'b0;
            st.pending                <= 1'b0;
            st.busy                   <= 1'b0;
            st.wait_cnt               <= ivd_pkg::WAIT_ZERO;
            st.read_done              <= 1'b0;
            st.read_data              <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        o_system_status_word_zero                   = '0;
        o_system_status_word_zero[ivd_pkg::PEND_BIT] = st.pending;
    end
    assign o_fetch_valid         = st.fetch_valid;
    assign o_fetch_addr          = st.fetch_addr;
    assign o_read_done           = st.read_done;
    assign o_read_data           = st.read_data;
    assign o_vector_read_pending = st.pending;

    // Checks
    sequence s_two_word(logic [15:0] a);
        o_fetch_valid && o_fetch_addr == a ##1 o_fetch_valid && o_fetch_addr == a + 16'h0001;
    endsequence

    property p_level_two;
        @(posedge i_clk) disable iff (!i_rst_n)
        (st.fsm == ivd_pkg::IVD_IDLE && i_ack_level_two && !i_ack_nmi) |-> ##2 s_two_word(ivd_pkg::VEC_LEVEL_TWO);
    endproperty
    a_level_two: assert property (p_level_two) else $error("level two fetch wrong");

    property p_level_one;
        @(posedge i_clk) disable iff (!i_rst_n)
        (st.fsm == ivd_pkg::IVD_IDLE && i_ack_level_one && !i_ack_level_two && !i_ack_nmi)
            |-> ##2 s_two_word(ivd_pkg::VEC_LEVEL_ONE);
    endproperty
    a_level_one: assert property (p_level_one) else $error("level one fetch wrong");

    property p_nmi;
        @(posedge i_clk) disable iff (!i_rst_n)
        (st.fsm == ivd_pkg::IVD_IDLE && i_ack_nmi) |-> ##2 (o_fetch_valid && o_fetch_addr == ivd_pkg::VEC_NMI);
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi vector wrong");

    property p_nmi_keeps;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ack_nmi || !ack_mask || st.fsm != ivd_pkg::IVD_IDLE) |=> $stable(st.vector_offset_register);
    endproperty
    a_nmi_keeps: assert property (p_nmi_keeps) else $error("offset changed without maskable load");

    property p_status_bit;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_system_status_word_zero ==
            ({{(ivd_pkg::STATUS_W-1){1'b0}}, o_vector_read_pending} << ivd_pkg::PEND_BIT);
    endproperty
    a_status_bit: assert property (p_status_bit) else $error("status word layout wrong");

    property p_load;
        @(posedge i_clk) disable iff (!i_rst_n)
        (st.fsm == ivd_pkg::IVD_IDLE && ack_mask && !i_ack_nmi && i_offset_valid)
            |=> st.vector_offset_register == $past(i_offset) && o_vector_read_pending;
    endproperty
    a_load: assert property (p_load) else $error("offset not loaded");

    property p_wait_pi;
        @(posedge i_clk) disable iff (!i_rst_n)
        (read_start && !st.src_evmgr) |-> ##1 !o_read_done [*5] ##1 o_read_done;
    endproperty
    a_wait_pi: assert property (p_wait_pi) else $error("peripheral read timing wrong");

    property p_wait_ev;
        @(posedge i_clk) disable iff (!i_rst_n)
        (read_start && st.src_evmgr) |-> ##1 !o_read_done [*2] ##1 o_read_done;
    endproperty
    a_wait_ev: assert property (p_wait_ev) else $error("event manager read timing wrong");

    property p_phantom;
        @(posedge i_clk) disable iff (!i_rst_n)
        (st.fsm == ivd_pkg::IVD_IDLE && ack_mask && !i_ack_nmi && !i_offset_valid)
            |=> st.vector_offset_register == OFFSET_W'(ivd_pkg::PHANTOM_OFFSET);
    endproperty
    a_phantom: assert property (p_phantom) else $error("phantom not loaded");

    property p_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        (read_start && !(st.fsm == ivd_pkg::IVD_IDLE && ack_mask && !i_ack_nmi)) |=> !o_vector_read_pending;
    endproperty
    a_clear: assert property (p_clear) else $error("pending not cleared by read");

endmodule

// File: hw/ivd_pkg.sv
// Package of constants and types for the interrupt vector dispatch block
package ivd_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          OFFSET_W        = 16;
    localparam int          STATUS_W        = 16;
    // Vector-table entry points of the CPU
    localparam logic [15:0] VEC_LEVEL_ONE   = 16'h0002;
    localparam logic [15:0] VEC_LEVEL_TWO   = 16'h0004;
    localparam logic [15:0] VEC_NMI         = 16'h0024;
    // Value loaded when nobody answers a maskable acknowledge
    localparam logic [15:0] PHANTOM_OFFSET  = 16'h0000;
    localparam logic [15:0] OFFSET_RESET    = 16'h0000;
    // Position of the pending flag in status word zero
    localparam int          PEND_BIT        = 0;
    // Extra read cycles by source of the vector
    localparam logic [2:0]  WAIT_PERIPH     = 3'h4;
    localparam logic [2:0]  WAIT_EVMGR      = 3'h1;
    localparam logic [2:0]  WAIT_ZERO       = 3'h0;
    localparam logic [1:0]  WORD_ONE        = 2'h1;

    typedef enum logic [2:0] {
        IVD_IDLE,
        IVD_FETCH0,
        IVD_FETCH1,
        IVD_WAIT,
        IVD_DONE
    } ivd_fsm_type;
endpackage

// File: dv/ivd_cpu_model.sv
// Partner model: peripherals and handler software facing the dispatch block
`timescale 1ns/10ps
// =======================================
// Acknowledge source and offset supplier
module ivd_cpu_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [1:0]  i_kind,
    input  wire logic        i_supply,
    input  wire logic [15:0] i_value,
    input  wire logic        i_evmgr,
    input  wire logic        i_pending,
    output logic             o_ack_level_one,
    output logic             o_ack_level_two,
    output logic             o_ack_nmi,
    output logic             o_offset_valid,
    output logic [15:0]      o_offset,
    output logic             o_offset_evmgr,
    output logic             o_global_interrupt_mask
);
    logic [15:0] last;
    // Maskable acks pass only while the global mask is clear
    assign o_ack_level_one = (i_kind == 2'h1) && !o_global_interrupt_mask;
    assign o_ack_level_two = (i_kind == 2'h2) && !o_global_interrupt_mask;
    assign o_ack_nmi       = (i_kind == 2'h3);
    assign o_offset_valid  = i_supply;
    assign o_offset_evmgr  = i_evmgr;
    // Idle offset lines show the inverse of the last value, so stale data cannot pass
    assign o_offset        = i_supply ? i_value : ~last;
    // Handler keeps maskables off after a non-maskable while a read is pending
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last <= 16'h0000;
            o_global_interrupt_mask <= 1'b0;
        end else begin
            if (i_supply) begin
                last <= i_value;
            end
            o_global_interrupt_mask <= i_pending && (o_ack_nmi || o_global_interrupt_mask);
        end
    end
endmodule

// File: dv/interrupt_vector_dispatch_tb.sv
// Self-checking testbench of the interrupt vector dispatch block
`timescale 1ns/10ps
module interrupt_vector_dispatch_tb;
    typedef struct packed {
        logic [1:0] kind; logic sup; logic [15:0] off; logic ev;
        logic [15:0] addr; logic pend; logic [15:0] data; logic [2:0] wt;
    } ivd_row_type;
    logic        clk, rst_n, sup, ev, read_req, a1, a2, an, ovld, oev, gim, fv, rdone, pend;
    logic [1:0]  kind;
    logic [15:0] val, off, addr, rdata, ssw;
    int          num_errors = 0;
    int          n_compared = 0;
    ivd_row_type rows [4];
    ivd_cpu_model model_u (.i_clk(clk), .i_rst_n(rst_n), .i_kind(kind), .i_supply(sup), .i_value(val),
        .i_evmgr(ev), .i_pending(pend), .o_ack_level_one(a1), .o_ack_level_two(a2), .o_ack_nmi(an),
        .o_offset_valid(ovld), .o_offset(off), .o_offset_evmgr(oev), .o_global_interrupt_mask(gim));
    ivd_dispatch dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ack_level_one(a1), .i_ack_level_two(a2),
        .i_ack_nmi(an), .i_offset_valid(ovld), .i_offset(off), .i_offset_evmgr(oev), .i_read_req(read_req),
        .o_fetch_valid(fv), .o_fetch_addr(addr), .o_read_done(rdone), .o_read_data(rdata),
        .o_system_status_word_zero(ssw), .o_vector_read_pending(pend));
    // =======================================
    // Clock and shared tasks
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic stop_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle acknowledge, driven just after an edge
    task automatic ack(input logic [1:0] k, input logic s, input logic [15:0] v, input logic e);
        kind = k; sup = s; val = v; ev = e;
        @(posedge clk); #1;
        kind = 2'h0; sup = 1'b0; ev = 1'b0;
    endtask
    // Two fetch words base then base+1, or none when blocked
    task automatic fetch(input logic [15:0] base, input logic on);
        @(posedge clk); #1; chk(16'(fv), 16'(on));
        if (on) chk(addr, base);
        @(posedge clk); #1; chk(16'(fv), 16'(on));
        if (on) chk(addr, base + 16'h0001);
        @(posedge clk); #1; chk(16'(fv), 16'h0000);
    endtask
    // Read of the offset register; latency counted in edges, bounded
    task automatic rd(input logic [15:0] exp, input logic [2:0] wt);
        int n;
        read_req = 1'b1;
        @(posedge clk); #1;
        read_req = 1'b0;
        chk(16'(pend), 16'h0000);
        n = 0;
        do begin
            @(posedge clk); #1;
            n++;
        end while (rdone !== 1'b1 && n < 10);
        if (n == 10) begin
            num_errors++;
            stop_test();
        end
        // The first edge after the request is the base cycle; the extra cycles follow it
        chk(16'(n), 16'(wt) + 16'h0001);
        chk(rdata, exp);
    endtask
    // =======================================
    // Main sequence: table rows, then hand-written cases
    initial begin
        rst_n = 1'b0; kind = 2'h0; sup = 1'b0; val = 16'h0000; ev = 1'b0; read_req = 1'b0;
        rows[0] = '{2'h2, 1'b1, 16'h1234, 1'b0, ivd_pkg::VEC_LEVEL_TWO, 1'b1, 16'h1234, ivd_pkg::WAIT_PERIPH};
        rows[1] = '{2'h1, 1'b1, 16'h00a5, 1'b1, ivd_pkg::VEC_LEVEL_ONE, 1'b1, 16'h00a5, ivd_pkg::WAIT_EVMGR};
        rows[2] = '{2'h1, 1'b0, 16'h0000, 1'b1, ivd_pkg::VEC_LEVEL_ONE, 1'b1, 16'h0000, ivd_pkg::WAIT_PERIPH};
        rows[3] = '{2'h3, 1'b0, 16'h0000, 1'b0, ivd_pkg::VEC_NMI, 1'b0, 16'h0000, ivd_pkg::WAIT_ZERO};
        repeat (20) @(posedge clk);
        #1;
        chk({fv, rdone, pend, ssw[12:0]}, 16'h0000);
        chk(addr, 16'h0000);
        chk(rdata, 16'h0000);
        chk(ssw, 16'h0000);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            ack(rows[i].kind, rows[i].sup, rows[i].off, rows[i].ev);
            fetch(rows[i].addr, 1'b1);
            chk(ssw, {15'h0000, rows[i].pend});
            if (rows[i].pend) rd(rows[i].data, rows[i].wt);
        end
        // Unread offset replaced by a later acknowledge
        ack(2'h2, 1'b1, 16'h1111, 1'b0);
        fetch(ivd_pkg::VEC_LEVEL_TWO, 1'b1);
        ack(2'h1, 1'b1, 16'h2222, 1'b1);
        fetch(ivd_pkg::VEC_LEVEL_ONE, 1'b1);
        rd(16'h2222, ivd_pkg::WAIT_EVMGR);
        // Load and read in one cycle: the read takes the old offset, the flag is set
        kind = 2'h2;
        sup = 1'b1;
        val = 16'h6666;
        ev = 1'b0;
        read_req = 1'b1;
        @(posedge clk);
        #1;
        kind = 2'h0;
        sup = 1'b0;
        read_req = 1'b0;
        chk(16'(pend), 16'h0001);
        fetch(ivd_pkg::VEC_LEVEL_TWO, 1'b1);
        chk(rdata, 16'h2222);
        rd(16'h6666, ivd_pkg::WAIT_PERIPH);
        // Non-maskable keeps the pending offset; maskables stay off until it is read
        ack(2'h2, 1'b1, 16'h3333, 1'b1);
        fetch(ivd_pkg::VEC_LEVEL_TWO, 1'b1);
        ack(2'h3, 1'b1, 16'h7777, 1'b0);
        fetch(ivd_pkg::VEC_NMI, 1'b1);
        chk(16'(pend), 16'h0001);
        ack(2'h1, 1'b1, 16'h4444, 1'b0);
        fetch(ivd_pkg::VEC_LEVEL_ONE, 1'b0);
        rd(16'h3333, ivd_pkg::WAIT_EVMGR);
        // Reset in mid-run drops the pending flag at once
        ack(2'h2, 1'b1, 16'h5555, 1'b0);
        fetch(ivd_pkg::VEC_LEVEL_TWO, 1'b1);
        rst_n = 1'b0;
        #1;
        chk(ssw, 16'h0000);
        @(posedge clk); #1;
        rst_n = 1'b1;
        chk(16'(pend), 16'h0000);
        // First acknowledge right after the release must work as usual
        ack(2'h1, 1'b1, 16'h0abc, 1'b0);
        fetch(ivd_pkg::VEC_LEVEL_ONE, 1'b1);
        rd(16'h0abc, ivd_pkg::WAIT_PERIPH);
        stop_test();
    end
endmodule
